// *** rtl/cox_exec.sv ***
// Execution logic for a small instruction subset, with a Wishbone slave.
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01: Halt clears powerdown_flag, sets watchdog_expiry_flag, no more.
// RULE_02: Halt zeroes watchdog_counter and its prescaler.
// RULE_03: Halt puts the core to sleep, oscillator stopped; nothing executes.
// RULE_04: Rotate right through carry: old carry to bit 7, bit 0 to carry.
// RULE_05: Destination select 0 writes accumulator, 1 writes file register.
// RULE_06: Literal minus accumulator to accumulator, arithmetic flags updated.
// RULE_07: File minus accumulator to destination, arithmetic flags updated.
// RULE_08: Accumulator xor file register to destination, updates Z only.
// RULE_09: Nibble exchange swaps halves of file register, no flags change.
// RULE_10: Accumulator xor literal into accumulator, updates Z only.
// RULE_11: Borrow flags are 1 when accumulator is at most the other operand.
module cox_exec (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [7:0] watchdog_counter,
  output logic [7:0] wdog_prescaler,
  output logic sleep_mode,
  output logic osc_run
);

  // --------------------------------------------------------------------------
  // Reset synchroniser
  // --------------------------------------------------------------------------
  logic rst_meta;
  logic rst_sync;

  // Every assertion below runs on the core clock and sleeps during reset.
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_sync);

  // The first stage feeds only the second one.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [7:0] acc, next_acc;
  logic [7:0] lit, next_lit;
  logic [6:0] faddr, next_faddr;
  logic [2:0] opc, next_opc;
  logic dest, next_dest;
  logic borrow_flag, next_borrow_flag;
  logic nibble_borrow_flag, next_nibble_borrow_flag;
  logic result_nil_flag, next_result_nil_flag;
  logic powerdown_flag, next_powerdown_flag;
  logic watchdog_expiry_flag, next_watchdog_expiry_flag;
  logic wdog_clr, next_wdog_clr;
  logic [7:0] next_wdog, next_presc;
  logic next_sleep, next_osc;
  logic [7:0] file_mem [cox_pkg::FILE_DEPTH];
  logic file_we;
  logic [6:0] file_wa;
  logic [7:0] file_wd;
  logic [31:0] next_dat;
  logic next_ack;
  logic [7:0] fval;
  logic [7:0] res;
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic [7:0] sub_a;
  logic acc_word;

  assign fval = file_mem[faddr];
  // The second operand follows the operation carried by the executing write.
  assign sub_a = (wb_dat_i[cox_pkg::CTRL_OP_LSB +: 3] ==
                  3'(cox_pkg::COX_OP_LSUB)) ? lit : fval;
  // Borrow flags set when the subtrahend does not exceed the minuend.
  assign diff = {1'b0, sub_a} - {1'b0, acc}; // [RULE_11]
  assign ndiff = {1'b0, sub_a[3:0]} - {1'b0, acc[3:0]}; // [RULE_11]
  assign acc_word = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // --------------------------------------------------------------------------
  // Next-state logic: bus access and instruction execution
  // --------------------------------------------------------------------------
  always_comb begin
    next_acc = acc;
    next_lit = lit;
    next_faddr = faddr;
    next_opc = opc;
    next_dest = dest;
    next_borrow_flag = borrow_flag;
    next_nibble_borrow_flag = nibble_borrow_flag;
    next_result_nil_flag = result_nil_flag;
    next_powerdown_flag = powerdown_flag;
    next_watchdog_expiry_flag = watchdog_expiry_flag;
    next_wdog_clr = 1'b0;
    next_wdog = watchdog_counter;
    next_presc = wdog_prescaler;
    next_sleep = sleep_mode;
    next_osc = osc_run;
    next_ack = acc_word;
    next_dat = wb_dat_o;
    file_we = 1'b0;
    file_wa = faddr;
    file_wd = 8'h00;
    res = 8'h00;
    if (acc_word) begin
      next_dat = 32'h0000_0000;
      case (wb_adr_i)
        cox_pkg::CTRL_OFF: begin
          next_dat[cox_pkg::CTRL_DEST_BIT] = dest;
          next_dat[cox_pkg::CTRL_OP_LSB +: 3] = opc;
        end
        cox_pkg::OPER_OFF: begin
          next_dat[cox_pkg::OPER_ACC_LSB +: 8] = acc;
          next_dat[cox_pkg::OPER_LIT_LSB +: 8] = lit;
          next_dat[cox_pkg::OPER_ADDR_LSB +: 7] = faddr;
        end
        cox_pkg::FILE_OFF: next_dat[7:0] = fval;
        cox_pkg::STAT_OFF: begin
          next_dat[cox_pkg::STAT_C_BIT] = borrow_flag;
          next_dat[cox_pkg::STAT_NB_BIT] = nibble_borrow_flag;
          next_dat[cox_pkg::STAT_Z_BIT] = result_nil_flag;
          next_dat[cox_pkg::STAT_PWDN_BIT] = powerdown_flag;
          next_dat[cox_pkg::STAT_TO_BIT] = watchdog_expiry_flag;
          next_dat[cox_pkg::STAT_SLEEP_BIT] = sleep_mode;
          next_dat[cox_pkg::STAT_CLRWD_BIT] = wdog_clr;
        end
        default: next_dat = 32'h0000_0000;
      endcase
    end
    if (acc_word && wb_we_i) begin
      case (wb_adr_i)
        cox_pkg::OPER_OFF: begin
          if (wb_sel_i[0]) next_acc = wb_dat_i[7:0];
          if (wb_sel_i[1]) next_lit = wb_dat_i[15:8];
          if (wb_sel_i[2]) next_faddr = wb_dat_i[22:16];
        end
        cox_pkg::FILE_OFF: begin
          file_we = wb_sel_i[0];
          file_wd = wb_dat_i[7:0];
        end
        cox_pkg::STAT_OFF: begin
          if (wb_sel_i[0]) begin
            next_borrow_flag = wb_dat_i[cox_pkg::STAT_C_BIT];
            next_nibble_borrow_flag = wb_dat_i[cox_pkg::STAT_NB_BIT];
            next_result_nil_flag = wb_dat_i[cox_pkg::STAT_Z_BIT];
          end
        end
        cox_pkg::CTRL_OFF: begin
          if (wb_sel_i[0]) begin
            next_dest = wb_dat_i[cox_pkg::CTRL_DEST_BIT];
            next_opc = wb_dat_i[cox_pkg::CTRL_OP_LSB +: 3];
            // Only a wake request leaves the stopped state.
            if (sleep_mode && wb_dat_i[cox_pkg::CTRL_WAKE_BIT]) begin
              next_sleep = 1'b0;
              next_osc = 1'b1;
            end
            // No instruction runs while the oscillator is stopped.
            if (wb_dat_i[cox_pkg::CTRL_GO_BIT] &&
                !sleep_mode) begin // [RULE_03]
              case (wb_dat_i[cox_pkg::CTRL_OP_LSB +: 3])
                cox_pkg::COX_OP_HALT: begin
                  next_powerdown_flag = 1'b0; // [RULE_01]
                  next_watchdog_expiry_flag = 1'b1; // [RULE_01]
                  next_wdog = cox_pkg::WDOG_ZERO; // [RULE_02]
                  next_presc = cox_pkg::PRESC_ZERO; // [RULE_02]
                  next_wdog_clr = 1'b1;
                  next_sleep = 1'b1; // [RULE_03]
                  next_osc = 1'b0; // [RULE_03]
                end
                cox_pkg::COX_OP_RRC: begin
                  res = {borrow_flag, fval[7:1]}; // [RULE_04]
                  next_borrow_flag = fval[0]; // [RULE_04]
                end
                cox_pkg::COX_OP_LSUB, cox_pkg::COX_OP_FSUB: begin
                  res = diff[7:0]; // [RULE_06] [RULE_07]
                  next_borrow_flag = ~diff[8]; // [RULE_11]
                  next_nibble_borrow_flag = ~ndiff[4]; // [RULE_11]
                  next_result_nil_flag = (diff[7:0] == 8'h00);
                end
                cox_pkg::COX_OP_FXOR, cox_pkg::COX_OP_LXOR: begin
                  res = acc ^ sub_a; // [RULE_08] [RULE_10]
                  if (wb_dat_i[cox_pkg::CTRL_OP_LSB +: 3] ==
                      3'(cox_pkg::COX_OP_LXOR)) begin
                    res = acc ^ lit; // [RULE_10]
                  end
                  next_result_nil_flag = (res == 8'h00); // [RULE_08]
                end
                cox_pkg::COX_OP_SWAP: begin
                  res = {fval[3:0], fval[7:4]}; // [RULE_09]
                end
                default: res = 8'h00;
              endcase
              // Literal forms always target the accumulator.
              case (wb_dat_i[cox_pkg::CTRL_OP_LSB +: 3])
                cox_pkg::COX_OP_LSUB, cox_pkg::COX_OP_LXOR: begin
                  next_acc = res; // [RULE_06] [RULE_10]
                end
                cox_pkg::COX_OP_RRC, cox_pkg::COX_OP_FSUB,
                cox_pkg::COX_OP_FXOR, cox_pkg::COX_OP_SWAP: begin
                  if (wb_dat_i[cox_pkg::CTRL_DEST_BIT]) begin // [RULE_05]
                    file_we = 1'b1;
                    file_wd = res;
                  end else begin
                    next_acc = res; // [RULE_05]
                  end
                end
                default: next_acc = acc;
              endcase
            end
          end
        end
        default: next_acc = acc;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      acc <= cox_pkg::ACC_RST;
      lit <= 8'h00;
      faddr <= 7'h00;
      opc <= 3'h0;
      dest <= 1'b0;
      borrow_flag <= 1'b0;
      nibble_borrow_flag <= 1'b0;
      result_nil_flag <= 1'b0;
      powerdown_flag <= cox_pkg::PWDN_RST;
      watchdog_expiry_flag <= cox_pkg::TO_RST;
      wdog_clr <= 1'b0;
      watchdog_counter <= cox_pkg::WDOG_ZERO;
      wdog_prescaler <= cox_pkg::PRESC_ZERO;
      sleep_mode <= 1'b0;
      osc_run <= 1'b1;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      acc <= next_acc;
      lit <= next_lit;
      faddr <= next_faddr;
      opc <= next_opc;
      dest <= next_dest;
      borrow_flag <= next_borrow_flag;
      nibble_borrow_flag <= next_nibble_borrow_flag;
      result_nil_flag <= next_result_nil_flag;
      powerdown_flag <= next_powerdown_flag;
      watchdog_expiry_flag <= next_watchdog_expiry_flag;
      wdog_clr <= next_wdog_clr;
      watchdog_counter <= next_wdog;
      wdog_prescaler <= next_presc;
      sleep_mode <= next_sleep;
      osc_run <= next_osc;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // File register array, written by bus or by an instruction result.
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      for (int i = 0; i < cox_pkg::FILE_DEPTH; i++) begin
        file_mem[i] <= cox_pkg::FILE_RST;
      end
    end else if (file_we) begin
      file_mem[file_wa] <= file_wd;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  logic exec_go;
  logic [2:0] go_op;
  assign exec_go = acc_word && wb_we_i && wb_sel_i[0] &&
                   (wb_adr_i == cox_pkg::CTRL_OFF) &&
                   wb_dat_i[cox_pkg::CTRL_GO_BIT] && !sleep_mode;
  assign go_op = wb_dat_i[cox_pkg::CTRL_OP_LSB +: 3];

  sequence s_halt;
    exec_go && go_op == 3'(cox_pkg::COX_OP_HALT);
  endsequence

  a_halt_flags: assert property ( // [RULE_01]
    s_halt |=> !powerdown_flag && watchdog_expiry_flag &&
      $stable(borrow_flag) && $stable(nibble_borrow_flag) &&
      $stable(result_nil_flag))
    else $error("halt flags wrong");
  a_halt_wdog: assert property ( // [RULE_02]
    s_halt |=> watchdog_counter == 8'h00 && wdog_prescaler == 8'h00)
    else $error("watchdog not cleared");
  a_sleep_hold: assert property ( // [RULE_03]
    s_halt |=> sleep_mode && !osc_run ##1 sleep_mode)
    else $error("sleep not entered");
  a_rotate_carry: assert property ( // [RULE_04]
    exec_go && go_op == 3'(cox_pkg::COX_OP_RRC)
    |=> borrow_flag == $past(fval[0]))
    else $error("rotate carry wrong");
  a_dest_acc: assert property ( // [RULE_05]
    exec_go && go_op == 3'(cox_pkg::COX_OP_SWAP) &&
    !wb_dat_i[cox_pkg::CTRL_DEST_BIT]
    |=> acc == {$past(fval[3:0]), $past(fval[7:4])})
    else $error("swap to accumulator wrong");
  a_lsub_val: assert property ( // [RULE_06]
    exec_go && go_op == 3'(cox_pkg::COX_OP_LSUB)
    |=> acc == $past(lit) - $past(acc))
    else $error("literal subtract wrong");
  a_sub_borrow: assert property ( // [RULE_11]
    exec_go && go_op == 3'(cox_pkg::COX_OP_FSUB)
    |=> borrow_flag == ($past(acc) <= $past(fval)))
    else $error("borrow wrong");
  a_lxor_zero: assert property ( // [RULE_10]
    exec_go && go_op == 3'(cox_pkg::COX_OP_LXOR)
    |=> result_nil_flag == (acc == 8'h00) && $stable(borrow_flag))
    else $error("xor zero flag wrong");

endmodule : cox_exec

// *** rtl/cox_pkg.sv ***
// Package of constants and types for the instruction subset execution block.
package cox_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] OPER_OFF = 4'h4;
  localparam logic [3:0] FILE_OFF = 4'h8;
  localparam logic [3:0] STAT_OFF = 4'hc;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_DEST_BIT = 1;
  localparam int CTRL_WAKE_BIT = 2;
  localparam int CTRL_OP_LSB = 4;
  localparam int OPER_ACC_LSB = 0;
  localparam int OPER_LIT_LSB = 8;
  localparam int OPER_ADDR_LSB = 16;
  localparam int STAT_C_BIT = 0;
  localparam int STAT_NB_BIT = 1;
  localparam int STAT_Z_BIT = 2;
  localparam int STAT_PWDN_BIT = 3;
  localparam int STAT_TO_BIT = 4;
  localparam int STAT_SLEEP_BIT = 5;
  localparam int STAT_CLRWD_BIT = 6;

  // --------------------------------------------------------------------------
  // Reset values and file register depth
  // --------------------------------------------------------------------------
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [7:0] WDOG_ZERO = 8'h00;
  localparam logic [7:0] PRESC_ZERO = 8'h00;
  localparam logic PWDN_RST = 1'b1;
  localparam logic TO_RST = 1'b1;
  localparam int FILE_DEPTH = 128;

  // --------------------------------------------------------------------------
  // Operation codes
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    COX_OP_HALT = 3'h0,
    COX_OP_RRC = 3'h1,
    COX_OP_LSUB = 3'h2,
    COX_OP_FSUB = 3'h3,
    COX_OP_FXOR = 3'h4,
    COX_OP_SWAP = 3'h5,
    COX_OP_LXOR = 3'h6
  } cox_op_e;

endpackage : cox_pkg

// *** bench/cox_exec_tb.sv ***
// Self-checking testbench for the instruction subset execution block.
`timescale 1ns/1ps

module cox_exec_tb;
  logic clock;
  logic resetn;
  logic [3:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0] wb_sel_i;
  logic wb_we_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] watchdog_counter;
  logic [7:0] wdog_prescaler;
  logic sleep_mode;
  logic osc_run;
  int n_errors;
  int tests_run;
  logic [31:0] rd;

  cox_exec u_dut (
    .clock(clock), .resetn(resetn), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .watchdog_counter(watchdog_counter),
    .wdog_prescaler(wdog_prescaler), .sleep_mode(sleep_mode),
    .osc_run(osc_run)
  );

  // ---------------------------------------------------------------------------
  // Clock, verdict and comparisons
  // ---------------------------------------------------------------------------
  // The clock toggles every half period of 5 ns.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // Compares an 8-bit result.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  // Compares a single flag or level.
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk1

  // ---------------------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------------------
  // One classic cycle; the request is held until ack is seen at an edge.
  task automatic xfer(input logic [3:0] adr, input logic we,
                      input logic [31:0] dat, output logic [31:0] q);
    int i;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t no bus acknowledge", $time);
      stop_test();
    end
  endtask : xfer

  task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
    logic [31:0] q;
    xfer(adr, 1'b1, dat, q);
  endtask : wr

  // Loads accumulator, literal, file address and the addressed file register.
  task automatic setup(input logic [7:0] acc, input logic [7:0] lit,
                       input logic [6:0] adr, input logic [7:0] fv);
    wr(cox_pkg::OPER_OFF, {9'h000, adr, lit, acc});
    wr(cox_pkg::FILE_OFF, {24'h000000, fv});
  endtask : setup

  // Writes carry, nibble borrow and zero directly.
  task automatic setc(input logic c, input logic nb, input logic z);
    wr(cox_pkg::STAT_OFF, {29'h00000000, z, nb, c});
  endtask : setc

  // Executes one operation with the given destination select.
  task automatic exec(input cox_pkg::cox_op_e op, input logic dest);
    wr(cox_pkg::CTRL_OFF, {25'h0000000, op, 2'h0, dest, 1'b1});
  endtask : exec

  // Reads back accumulator, file register and the three arithmetic flags.
  task automatic chk_res(input logic [7:0] acc, input logic [7:0] fv,
                         input logic c, input logic nb, input logic z);
    xfer(cox_pkg::OPER_OFF, 1'b0, 32'h0, rd);
    chk8(rd[7:0], acc);
    xfer(cox_pkg::FILE_OFF, 1'b0, 32'h0, rd);
    chk8(rd[7:0], fv);
    xfer(cox_pkg::STAT_OFF, 1'b0, 32'h0, rd);
    chk1(rd[cox_pkg::STAT_C_BIT], c);
    chk1(rd[cox_pkg::STAT_NB_BIT], nb);
    chk1(rd[cox_pkg::STAT_Z_BIT], z);
  endtask : chk_res

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Rotate right through carry, into the file register and the accumulator.
  task automatic t_rotate();
    setup(8'h33, 8'h00, 7'h7f, 8'h81);
    setc(1'b1, 1'b0, 1'b0);
    exec(cox_pkg::COX_OP_RRC, 1'b1);
    chk_res(8'h33, 8'hc0, 1'b1, 1'b0, 1'b0);
    setc(1'b0, 1'b1, 1'b1);
    exec(cox_pkg::COX_OP_RRC, 1'b0);
    chk_res(8'h60, 8'hc0, 1'b0, 1'b1, 1'b1);
  endtask : t_rotate

  // Literal subtract at the equal, below and above boundaries; file subtract below and above only.
  task automatic t_sub();
    setup(8'h05, 8'h05, 7'h10, 8'h00);
    exec(cox_pkg::COX_OP_LSUB, 1'b1);
    chk_res(8'h00, 8'h00, 1'b1, 1'b1, 1'b1);
    setup(8'h06, 8'h05, 7'h10, 8'h00);
    exec(cox_pkg::COX_OP_LSUB, 1'b0);
    chk_res(8'hff, 8'h00, 1'b0, 1'b0, 1'b0);
    setup(8'h1f, 8'h20, 7'h10, 8'h00);
    exec(cox_pkg::COX_OP_LSUB, 1'b0);
    chk_res(8'h01, 8'h00, 1'b1, 1'b0, 1'b0);
    setup(8'h01, 8'h00, 7'h22, 8'h10);
    setc(1'b0, 1'b1, 1'b1);
    exec(cox_pkg::COX_OP_FSUB, 1'b1);
    chk_res(8'h01, 8'h0f, 1'b1, 1'b0, 1'b0);
    setup(8'h20, 8'h00, 7'h22, 8'h13);
    exec(cox_pkg::COX_OP_FSUB, 1'b0);
    chk_res(8'hf3, 8'h13, 1'b0, 1'b1, 1'b0);
  endtask : t_sub

  // Both exclusive-OR forms and the nibble exchange.
  task automatic t_logic();
    setup(8'h5a, 8'h00, 7'h30, 8'h5a);
    setc(1'b1, 1'b1, 1'b0);
    exec(cox_pkg::COX_OP_FXOR, 1'b1);
    chk_res(8'h5a, 8'h00, 1'b1, 1'b1, 1'b1);
    exec(cox_pkg::COX_OP_FXOR, 1'b0);
    chk_res(8'h5a, 8'h00, 1'b1, 1'b1, 1'b0);
    setup(8'h00, 8'h00, 7'h40, 8'ha5);
    setc(1'b1, 1'b0, 1'b1);
    exec(cox_pkg::COX_OP_SWAP, 1'b1);
    chk_res(8'h00, 8'h5a, 1'b1, 1'b0, 1'b1);
    exec(cox_pkg::COX_OP_SWAP, 1'b0);
    chk_res(8'ha5, 8'h5a, 1'b1, 1'b0, 1'b1);
    setup(8'hc3, 8'hc3, 7'h40, 8'h5a);
    setc(1'b1, 1'b1, 1'b0);
    exec(cox_pkg::COX_OP_LXOR, 1'b1);
    chk_res(8'h00, 8'h5a, 1'b1, 1'b1, 1'b1);
    setup(8'h0f, 8'hf0, 7'h40, 8'h5a);
    exec(cox_pkg::COX_OP_LXOR, 1'b0);
    chk_res(8'hff, 8'h5a, 1'b1, 1'b1, 1'b0);
  endtask : t_logic

  // Halt, an execute refused while asleep, then wake and execute again.
  task automatic t_halt();
    setup(8'h05, 8'h05, 7'h40, 8'h11);
    setc(1'b1, 1'b0, 1'b1);
    exec(cox_pkg::COX_OP_HALT, 1'b0);
    chk_res(8'h05, 8'h11, 1'b1, 1'b0, 1'b1);
    chk1(rd[cox_pkg::STAT_PWDN_BIT], 1'b0);
    chk1(rd[cox_pkg::STAT_TO_BIT], 1'b1);
    chk1(rd[cox_pkg::STAT_SLEEP_BIT], 1'b1);
    chk8(watchdog_counter, 8'h00);
    chk8(wdog_prescaler, 8'h00);
    chk1(sleep_mode, 1'b1);
    chk1(osc_run, 1'b0);
    exec(cox_pkg::COX_OP_LSUB, 1'b0);
    chk_res(8'h05, 8'h11, 1'b1, 1'b0, 1'b1);
    wr(cox_pkg::CTRL_OFF, 32'h00000004);
    chk1(sleep_mode, 1'b0);
    chk1(osc_run, 1'b1);
    exec(cox_pkg::COX_OP_LSUB, 1'b0);
    chk_res(8'h00, 8'h11, 1'b1, 1'b1, 1'b1);
  endtask : t_halt

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  // Resets the block, checks reset state, then runs every scenario.
  initial begin
    n_errors = 0;
    tests_run = 0;
    resetn = 1'b0;
    wb_adr_i = 4'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    xfer(cox_pkg::STAT_OFF, 1'b0, 32'h0, rd);
    chk1(rd[cox_pkg::STAT_PWDN_BIT], cox_pkg::PWDN_RST);
    chk1(rd[cox_pkg::STAT_TO_BIT], cox_pkg::TO_RST);
    chk1(osc_run, 1'b1);
    xfer(4'h2, 1'b0, 32'h0, rd);
    chk8(rd[7:0], 8'h00);
    t_rotate();
    t_sub();
    t_logic();
    t_halt();
    stop_test();
  end
endmodule : cox_exec_tb
